// File: design/dls_pkg.sv
package dls_pkg;

  // Pixel and stream word layout.
  localparam int PIX_W = 24;
  localparam int WORD_W = 26;
  localparam int HSS_BIT = 24;
  localparam int VSS_BIT = 25;

  // Line geometry and buffering.
  localparam int X_W = 13;
  localparam int Y_W = 11;
  localparam int ADDR_W = 12;
  localparam int LINE_MAX = 4096;
  localparam int LINE_BUFS = 4;
  localparam int FIFO_DEPTH = 4;

  // Output lags the input by this many line times.
  localparam logic [1:0] DELAY_PLAIN = 2'h2;
  localparam logic [1:0] DELAY_COMP = 2'h3;

  // Largest overlap or dummy pixel count per half.
  localparam logic [5:0] OVL_MAX = 6'h20;
  localparam logic [5:0] OVL_EVEN_MASK = 6'h3e;

  // Debug colour-bar raster timing.
  localparam logic [X_W-1:0] CB_H_TOTAL = 13'h1100;
  localparam logic [X_W-1:0] CB_H_SYNC = 13'h0020;
  localparam logic [X_W-1:0] CB_H_START = 13'h0040;
  localparam logic [Y_W-1:0] CB_V_TOTAL = 11'h460;
  localparam logic [Y_W-1:0] CB_V_SYNC = 11'h004;
  localparam logic [Y_W-1:0] CB_V_START = 11'h010;
  localparam int CB_BAR_LSB = 6;

  // Where panel commands go.
  typedef enum logic [1:0] {
    CMD_TO_LEFT = 2'b00,
    CMD_TO_RIGHT = 2'b01,
    CMD_TO_BOTH = 2'b10
  } dls_cmd_route_type;

  // Per-link line sequencer.
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SYNC = 2'b01,
    LINK_PORCH = 2'b10,
    LINK_PIXELS = 2'b11
  } dls_link_state_type;

endpackage

// File: design/dls_stream_if.sv
`timescale 1ns/1ps
// Valid/ready word stream between the sequencers and the FIFOs.
interface dls_stream_if #(parameter int WIDTH = 26) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// File: design/dls_fifo.sv
`timescale 1ns/1ps
module dls_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Streams
  dls_stream_if.rx in_s,
  dls_stream_if.tx out_s
);
  import dls_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // DEPTH must be a power of two so that the pointers wrap by themselves.
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  assign in_s.ready = count != (AW+1)'(DEPTH);
  assign out_s.valid = count != '0;
  assign out_s.data = store[rd_ptr];

  // Storage needs no reset; only the pointers and fill level define what is valid.
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr] <= in_s.data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // dls_fifo

// File: design/dls_dither.sv
`timescale 1ns/1ps
module dls_dither (
  // Control
  input wire logic enable,
  // Position of the pixel in space and time
  input wire logic [dls_pkg::X_W-1:0] x_pos,
  input wire logic [dls_pkg::Y_W-1:0] y_pos,
  input wire logic [1:0] frame,
  // Pixel
  input wire logic [dls_pkg::PIX_W-1:0] pixel_in,
  output logic [dls_pkg::PIX_W-1:0] pixel_out
);
  import dls_pkg::*;

  logic [1:0] thr;

  // A 2x2 ordered matrix rotated every frame spreads the two dropped bits.
  assign thr = {x_pos[0] ^ y_pos[0], y_pos[0]} + frame;

  // One slice per colour component.
  for (genvar c = 0; c < 3; c++) begin : g_comp
    logic [7:0] comp;
    logic up;
    assign comp = pixel_in[8*c+7:8*c];
    // Saturate so the plus-one step never wraps white to black.
    assign up = (comp[1:0] > thr) && (comp[7:2] != 6'h3f);
    assign pixel_out[8*c+7:8*c] =
      enable ? {comp[7:2] + {5'h00, up}, 2'b00} : comp;
  end

endmodule // dls_dither

// File: design/dls_top.sv
`timescale 1ns/1ps
module dls_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Upstream video from the receiver
  input wire logic [dls_pkg::PIX_W-1:0] in_pixel,
  input wire logic in_de,
  input wire logic in_hsync,
  input wire logic in_vsync,
  // Line splitting configuration
  input wire logic dual_link_en,
  input wire logic port_swap,
  input wire logic [dls_pkg::X_W-1:0] line_width,
  input wire logic [5:0] overlap_count,
  input wire logic dummy_mode,
  input wire logic extras_suppress,
  input wire logic [dls_pkg::PIX_W-1:0] dummy_color,
  // Link skew
  input wire logic [7:0] left_link_vsync_delay,
  input wire logic [7:0] right_link_vsync_delay,
  input wire logic [11:0] left_link_hback_porch,
  input wire logic [11:0] right_link_hback_porch,
  // Video processing
  input wire logic compress_en,
  input wire logic dither_en,
  input wire logic color_bar_en,
  // Panel commands
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire dls_pkg::dls_cmd_route_type cmd_route,
  // Physical transmit ports
  input wire logic [1:0] port_ready,
  output logic port_valid [2],
  output logic [dls_pkg::PIX_W-1:0] port_pixel [2],
  output logic port_hss [2],
  output logic port_vss [2],
  output logic port_cmd_valid [2],
  output logic [7:0] port_cmd_data [2]
);
  import dls_pkg::*;
  logic [X_W-1:0] cb_h;
  logic [Y_W-1:0] cb_v;
  logic [X_W-1:0] cb_x;
  logic cb_active;
  logic src_hsync;
  logic src_vsync;
  logic src_de;
  logic [PIX_W-1:0] src_pixel;
  logic hs_d;
  logic vs_d;
  logic hs_edge;
  logic vs_edge;
  logic [PIX_W-1:0] line_mem [LINE_BUFS][LINE_MAX];
  logic [1:0] wr_line;
  logic [1:0] rd_line;
  logic [X_W-1:0] wr_x;
  logic [Y_W-1:0] y_cnt;
  logic [1:0] frame;
  logic [X_W-1:0] half;
  logic [X_W-1:0] line_half;
  logic [5:0] ovl_clip;
  logic [X_W-1:0] ove;
  logic [7:0] vs_delay [2];
  logic [11:0] hbp [2];
  logic fo_valid [2];
  logic [WORD_W-1:0] fo_data [2];
  logic fo_ready [2];
  assign vs_delay[0] = left_link_vsync_delay;
  assign vs_delay[1] = right_link_vsync_delay;
  assign hbp[0] = left_link_hback_porch;
  assign hbp[1] = right_link_hback_porch;
  // Colour-bar raster counters; free running only while the source is on.
  always_ff @(posedge clk) begin
    if (reset || !color_bar_en) begin
      cb_h <= '0;
      cb_v <= '0;
    end else if (cb_h == CB_H_TOTAL - 1'b1) begin
      cb_h <= '0;
      cb_v <= (cb_v == CB_V_TOTAL - 1'b1) ? '0 : cb_v + 1'b1;
    end else begin
      cb_h <= cb_h + 1'b1;
    end
  end

  // Eight vertical bars, white first; the bar width is fixed in pixels.
  assign cb_x = cb_h - CB_H_START;
  assign cb_active = (cb_h >= CB_H_START) &&
                     (cb_h < CB_H_START + line_width) &&
                     (cb_v >= CB_V_START);

  // Source select: the bar generator replaces the received video entirely.
  always_comb begin
    if (color_bar_en) begin
      src_hsync = cb_h < CB_H_SYNC;
      src_vsync = cb_v < CB_V_SYNC;
      src_de = cb_active;
      src_pixel = {{8{~cb_x[CB_BAR_LSB+2]}}, {8{~cb_x[CB_BAR_LSB+1]}},
                   {8{~cb_x[CB_BAR_LSB]}}};
    end else begin
      src_hsync = in_hsync;
      src_vsync = in_vsync;
      src_de = in_de;
      src_pixel = in_pixel;
    end
  end

  // Leading-edge detection of the recovered syncs.
  always_ff @(posedge clk) begin
    if (reset) begin
      hs_d <= 1'b0;
      vs_d <= 1'b0;
    end else begin
      hs_d <= src_hsync;
      vs_d <= src_vsync;
    end
  end
  assign hs_edge = src_hsync && !hs_d;
  assign vs_edge = src_vsync && !vs_d;
  // Overlap count: clipped to the maximum, forced even, or dropped entirely.
  assign ovl_clip = (overlap_count > OVL_MAX) ? OVL_MAX : overlap_count;
  assign ove = extras_suppress ? '0 :
               {7'h00, ovl_clip & OVL_EVEN_MASK};
  assign half = {1'b0, line_width[X_W-1:1]};

  // Write side: every line goes to the next of four buffers, so a line is
  // never overwritten while one of the links may still be reading it.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_line <= '0;
      rd_line <= '0;
      wr_x <= '0;
      y_cnt <= '0;
      line_half <= '0;
    end else if (hs_edge) begin
      wr_line <= wr_line + 1'b1;
      rd_line <= wr_line + 1'b1 -
                 (compress_en ? DELAY_COMP : DELAY_PLAIN);
      wr_x <= '0;
      y_cnt <= vs_edge ? '0 : y_cnt + 1'b1;
      line_half <= half;
    end else if (src_de && !wr_x[X_W-1]) begin
      wr_x <= wr_x + 1'b1;
    end
  end

  // Line memory; pixels past the buffer length are dropped.
  always_ff @(posedge clk) begin
    if (src_de && !hs_edge && !wr_x[X_W-1]) begin
      line_mem[wr_line][wr_x[ADDR_W-1:0]] <= src_pixel;
    end
  end

  // Frame counter steers the dither pattern over time.
  always_ff @(posedge clk) begin
    if (reset) begin
      frame <= '0;
    end else if (vs_edge) begin
      frame <= frame + 1'b1;
    end
  end

  // One sequencer, dither stage and FIFO per logical link: 0 left, 1 right.
  for (genvar l = 0; l < 2; l++) begin : g_link
    dls_link_state_type st;
    logic [11:0] porch;
    logic [X_W-1:0] idx;
    logic [X_W-1:0] rem;
    logic [X_W-1:0] pos;
    logic [X_W-1:0] first;
    logic [X_W-1:0] count;
    logic link_on;
    logic [PIX_W-1:0] prev;
    logic [PIX_W-1:0] raw;
    logic [PIX_W-1:0] pix_sel;
    logic [PIX_W-1:0] stage;
    logic [PIX_W-1:0] dith;
    logic extra;
    logic push;
    logic advance;
    logic vss_arm;
    logic [7:0] vcnt;
    logic vss_flag;
    logic cur_arm;
    logic [7:0] cur_cnt;
    dls_stream_if #(.WIDTH(WORD_W)) in_s ();
    dls_stream_if #(.WIDTH(WORD_W)) out_s ();
    // Span of the line this link reads, in buffer pixel indices.
    always_comb begin
      link_on = dual_link_en || (l == 0);
      if (!dual_link_en) begin
        first = '0;
        count = line_width;
      end else if (l == 0) begin
        first = '0;
        count = half + ove;
      end else begin
        first = half - ove;
        count = line_width - half + ove;
      end
    end

    // Vsync tracking: the sync-start word of the line that comes the
    // programmed number of lines after the vsync edge carries the VSS flag.
    assign cur_arm = vs_edge || vss_arm;
    assign cur_cnt = vs_edge ? vs_delay[l] : vcnt;
    always_ff @(posedge clk) begin
      if (reset) begin
        vss_arm <= 1'b0;
        vcnt <= '0;
        vss_flag <= 1'b0;
      end else if (hs_edge) begin
        vss_flag <= cur_arm && (cur_cnt == '0);
        vss_arm <= cur_arm && (cur_cnt != '0);
        vcnt <= (cur_cnt == '0) ? '0 : cur_cnt - 1'b1;
      end else if (vs_edge) begin
        vss_arm <= 1'b1;
        vcnt <= vs_delay[l];
      end
    end

    // Line sequencer: sync word, back porch, then the pixels of the span.
    // Every input hsync edge restarts it, which locks the link period to
    // the input period; a span that has not drained by then is cut short.
    always_ff @(posedge clk) begin
      if (reset) begin
        st <= LINK_IDLE;
        porch <= '0;
        idx <= '0;
        rem <= '0;
        pos <= '0;
        prev <= '0;
      end else if (hs_edge) begin
        st <= link_on ? LINK_SYNC : LINK_IDLE;
        idx <= first;
        rem <= count;
        pos <= '0;
      end else begin
        unique case (st)
          LINK_IDLE: st <= LINK_IDLE;
          LINK_SYNC: begin
            if (in_s.ready) begin
              if (hbp[l] == '0) begin
                st <= LINK_PIXELS;
              end else begin
                st <= LINK_PORCH;
                porch <= hbp[l] - 1'b1;
              end
            end
          end
          LINK_PORCH: begin
            if (porch == '0) begin
              st <= LINK_PIXELS;
            end else begin
              porch <= porch - 1'b1;
            end
          end
          LINK_PIXELS: begin
            if (rem == '0) begin
              st <= LINK_IDLE;
            end else if (advance) begin
              idx <= idx + 1'b1;
              rem <= rem - 1'b1;
              pos <= pos + 1'b1;
              prev <= pix_sel;
            end
          end
        endcase
      end
    end

    // Extras are the pixels beyond this link's own half.
    assign extra = dual_link_en &&
                   ((l == 0) ? (idx >= line_half) : (idx < line_half));
    assign raw = line_mem[rd_line][idx[ADDR_W-1:0]];
    assign pix_sel = (extra && dummy_mode) ? dummy_color : raw;

    // Compression averages each pixel pair, so only odd positions emit.
    for (genvar c = 0; c < 3; c++) begin : g_avg
      logic [8:0] sum;
      assign sum = {1'b0, prev[8*c+7:8*c]} + {1'b0, pix_sel[8*c+7:8*c]};
      assign stage[8*c+7:8*c] =
        compress_en ? sum[8:1] : pix_sel[8*c+7:8*c];
    end

    dls_dither u_dither (
      .enable(dither_en),
      .x_pos(compress_en ? {1'b0, pos[X_W-1:1]} : pos),
      .y_pos(y_cnt),
      .frame(frame),
      .pixel_in(stage),
      .pixel_out(dith)
    );
    assign push = (st == LINK_PIXELS) && (rem != '0) &&
                  (!compress_en || pos[0]);
    // The FIFO's ready stalls the sequencer when the port backs up.
    assign advance = !push || in_s.ready;
    assign in_s.valid = (st == LINK_SYNC) || push;
    assign in_s.data = (st == LINK_SYNC) ?
                       {vss_flag, 1'b1, {PIX_W{1'b0}}} :
                       {2'b00, dith};

    dls_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .in_s(in_s),
      .out_s(out_s)
    );
    assign fo_valid[l] = out_s.valid;
    assign fo_data[l] = out_s.data;
    // The FIFO drains into whichever port this link is mapped to.
    assign fo_ready[l] = !port_valid[1'(l) ^ port_swap] ||
                         port_ready[1'(l) ^ port_swap];
    assign out_s.ready = fo_ready[l];
  end

  // Physical ports: output registers and command routing per port.
  // Changing the swap setting mid-line may hand a word to the wrong port.
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic src;
    logic hit;
    assign src = 1'(p) ^ port_swap;
    assign hit = (cmd_route == CMD_TO_BOTH) ||
                 (src ? (cmd_route == CMD_TO_RIGHT)
                      : (cmd_route == CMD_TO_LEFT));

    always_ff @(posedge clk) begin
      if (reset) begin
        port_valid[p] <= 1'b0;
        port_pixel[p] <= '0;
        port_hss[p] <= 1'b0;
        port_vss[p] <= 1'b0;
      end else if (!port_valid[p] || port_ready[p]) begin
        port_valid[p] <= fo_valid[src];
        port_pixel[p] <= fo_data[src][PIX_W-1:0];
        port_hss[p] <= fo_valid[src] && fo_data[src][HSS_BIT];
        port_vss[p] <= fo_valid[src] && fo_data[src][VSS_BIT];
      end
    end

    // Commands pass through in one cycle, on one link or both at once.
    always_ff @(posedge clk) begin
      if (reset) begin
        port_cmd_valid[p] <= 1'b0;
        port_cmd_data[p] <= '0;
      end else begin
        port_cmd_valid[p] <= cmd_valid && hit;
        port_cmd_data[p] <= cmd_data;
      end
    end
  end

endmodule // dls_top

// File: sim/dls_properties.sv
`timescale 1ns/1ps
module dls_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched inputs
  input wire logic in_hsync,
  input wire logic dual_link_en,
  input wire logic port_swap,
  input wire logic dither_en,
  input wire logic color_bar_en,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_data,
  input wire dls_pkg::dls_cmd_route_type cmd_route,
  input wire logic [1:0] port_ready,
  // Watched outputs
  input wire logic port_valid [2],
  input wire logic [dls_pkg::PIX_W-1:0] port_pixel [2],
  input wire logic port_hss [2],
  input wire logic port_cmd_valid [2],
  input wire logic [7:0] port_cmd_data [2]
);
  import dls_pkg::*;
  logic [8:0] dith_cyc;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Lines buffered before dither was enabled must drain before it is judged.
  always_ff @(posedge clk) begin
    if (reset || !dither_en) dith_cyc <= 9'h000;
    else if (!dith_cyc[8]) dith_cyc <= dith_cyc + 9'h001;
  end
  property p_cmd_left;
    cmd_valid && cmd_route == CMD_TO_LEFT |=> port_cmd_valid[port_swap]
      && !port_cmd_valid[!port_swap]
      && port_cmd_data[port_swap] == $past(cmd_data);
  endproperty
  a_cmd_left: assert property (p_cmd_left)
    else $error("left command not on left port");
  property p_cmd_right;
    cmd_valid && cmd_route == CMD_TO_RIGHT |=> port_cmd_valid[!port_swap]
      && !port_cmd_valid[port_swap]
      && port_cmd_data[!port_swap] == $past(cmd_data);
  endproperty
  a_cmd_right: assert property (p_cmd_right)
    else $error("right command not on right port");
  property p_cmd_both;
    cmd_valid && cmd_route == CMD_TO_BOTH |=> port_cmd_valid[0]
      && port_cmd_valid[1] && port_cmd_data[1] == $past(cmd_data)
      && port_cmd_data[0] == $past(cmd_data);
  endproperty
  a_cmd_both: assert property (p_cmd_both)
    else $error("shared command missing on a port");
  property p_cmd_cause;
    port_cmd_valid[0] || port_cmd_valid[1] |->
      $past(cmd_valid) && $past(cmd_route) != 2'h3;
  endproperty
  a_cmd_cause: assert property (p_cmd_cause)
    else $error("command pulse without a routed request");
  property p_hss_lock;
    $rose(in_hsync) && !color_bar_en && port_ready == 2'h3 |->
      ##3 port_valid[port_swap] && port_hss[port_swap];
  endproperty
  a_hss_lock: assert property (p_hss_lock)
    else $error("sync word not three cycles after hsync edge");
  property p_single;
    !dual_link_en && !$past(dual_link_en, 8) |-> !port_valid[!port_swap];
  endproperty
  a_single: assert property (p_single)
    else $error("right port active in single link mode");
  property p_dither;
    port_valid[0] && !port_hss[0] && dith_cyc[8] |->
      port_pixel[0][1:0] == 2'h0 && port_pixel[0][9:8] == 2'h0
      && port_pixel[0][17:16] == 2'h0;
  endproperty
  a_dither: assert property (p_dither)
    else $error("dithered pixel has low bits set");
  property p_hold;
    port_valid[0] && !port_ready[0] |=> port_valid[0]
      && $stable(port_pixel[0]) && $stable(port_hss[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("stalled word changed before acceptance");
endmodule // dls_properties

bind dls_top dls_properties u_props (
  .clk(clk), .reset(reset), .in_hsync(in_hsync),
  .dual_link_en(dual_link_en), .port_swap(port_swap),
  .dither_en(dither_en), .color_bar_en(color_bar_en),
  .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_route(cmd_route),
  .port_ready(port_ready), .port_valid(port_valid),
  .port_pixel(port_pixel), .port_hss(port_hss),
  .port_cmd_valid(port_cmd_valid), .port_cmd_data(port_cmd_data)
);

// File: sim/dls_panel_model.sv
`timescale 1ns/1ps
module dls_panel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Stall request from the bench
  input wire logic [1:0] stall,
  // Transmit ports
  input wire logic port_valid [2],
  input wire logic [dls_pkg::PIX_W-1:0] port_pixel [2],
  input wire logic port_hss [2],
  input wire logic port_vss [2],
  output logic [1:0] port_ready
);
  import dls_pkg::*;
  logic [X_W-1:0] cnt [2];
  logic [PIX_W-1:0] first [2];
  logic [PIX_W-1:0] last [2];
  logic [7:0] gap [2];
  logic [7:0] since [2];
  logic [7:0] idle [2];
  // A stalled controller withholds ready; it never drops a word.
  assign port_ready = ~stall;
  // Per-port line bookkeeping; gap includes stalls, so skew runs unstalled.
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      idle[p] <= idle[p] + 8'h01;
      if (reset) begin
        cnt[p] <= '0;
        since[p] <= 8'h00;
      end else if (port_valid[p] && port_ready[p]) begin
        if (port_hss[p]) begin
          cnt[p] <= '0;
          idle[p] <= 8'h00;
          since[p] <= port_vss[p] ? 8'h00 : since[p] + 8'h01;
        end else begin
          if (cnt[p] == '0) begin
            first[p] <= port_pixel[p];
            gap[p] <= idle[p];
          end
          last[p] <= port_pixel[p];
          cnt[p] <= cnt[p] + 1'b1;
        end
      end
    end
  end
endmodule // dls_panel_model

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import dls_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [PIX_W-1:0] in_pixel = '0;
  logic in_de = 1'b0, in_hsync = 1'b0, in_vsync = 1'b0;
  logic dual_link_en = 1'b0, port_swap = 1'b0, dummy_mode = 1'b0;
  logic extras_suppress = 1'b0, compress_en = 1'b0, dither_en = 1'b0;
  logic color_bar_en = 1'b0, cmd_valid = 1'b0;
  logic [X_W-1:0] line_width = 13'h0010;
  logic [5:0] overlap_count = 6'h00;
  logic [PIX_W-1:0] dummy_color = 24'h3c5a96;
  logic [7:0] left_link_vsync_delay = 8'h01, right_link_vsync_delay = 8'h03;
  logic [11:0] left_link_hback_porch = 12'h004;
  logic [11:0] right_link_hback_porch = 12'h014;
  logic [7:0] cmd_data = 8'h00;
  dls_cmd_route_type cmd_route = CMD_TO_LEFT;
  logic [1:0] port_ready, stall = 2'h0, stall_req = 2'h0;
  logic port_valid [2], port_hss [2], port_vss [2], port_cmd_valid [2];
  logic [PIX_W-1:0] port_pixel [2];
  logic [7:0] port_cmd_data [2];
  logic [7:0] line_no = 8'h00;
  logic [1:0] cmd_exp [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  int n_mismatch = 0, checks = 0, cycles = 0;

  dls_top DUT (
    .clk(clk), .reset(reset), .in_pixel(in_pixel), .in_de(in_de),
    .in_hsync(in_hsync), .in_vsync(in_vsync), .dual_link_en(dual_link_en),
    .port_swap(port_swap), .line_width(line_width),
    .overlap_count(overlap_count), .dummy_mode(dummy_mode),
    .extras_suppress(extras_suppress), .dummy_color(dummy_color),
    .left_link_vsync_delay(left_link_vsync_delay),
    .right_link_vsync_delay(right_link_vsync_delay),
    .left_link_hback_porch(left_link_hback_porch),
    .right_link_hback_porch(right_link_hback_porch),
    .compress_en(compress_en), .dither_en(dither_en),
    .color_bar_en(color_bar_en), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_route(cmd_route), .port_ready(port_ready),
    .port_valid(port_valid), .port_pixel(port_pixel), .port_hss(port_hss),
    .port_vss(port_vss), .port_cmd_valid(port_cmd_valid),
    .port_cmd_data(port_cmd_data)
  );
  dls_panel_model PANEL (
    .clk(clk), .reset(reset), .stall(stall), .port_valid(port_valid),
    .port_pixel(port_pixel), .port_hss(port_hss), .port_vss(port_vss),
    .port_ready(port_ready)
  );

  // Free-running 100 MHz clock.
  initial forever #5 clk = ~clk;

  // Cuts a hang short; the tests need about 86000 of these cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 97000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_pix(input string what, input logic [PIX_W-1:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_cnt(input string what, input logic [X_W-1:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d seen %0d", what, e, g);
    end
  endtask

  // Source pixel at buffer index i, or 2i when compressed, of the line now on the links.
  function automatic logic [PIX_W-1:0] pix(input logic [X_W-1:0] i,
                                           input logic cp);
    logic [7:0] r;
    r = 8'h10 + (cp ? 8'(i) << 1 : 8'(i));
    return {r, 8'h20, line_no - (cp ? 8'h04 : 8'h03)};
  endfunction

  // One input line; the panel stalls mid-line as stall_req asks.
  task automatic send_line(input logic vs);
    @(posedge clk);
    in_hsync <= 1'b1;
    in_vsync <= vs;
    repeat (4) @(posedge clk);
    in_hsync <= 1'b0;
    in_vsync <= 1'b0;
    for (int x = 0; x < 16; x++) begin
      @(posedge clk);
      in_de <= 1'b1;
      in_pixel <= {8'h10 + 8'(x), 8'h20, line_no};
      if (x == 6) stall <= stall_req;
      if (x == 12) stall <= 2'h0;
    end
    @(posedge clk);
    in_de <= 1'b0;
    repeat (42) @(posedge clk);
    line_no++;
  endtask

  // Configure, stream five lines, then judge the last line on each link.
  task automatic run(input string name, input logic dl, sw, dm, sp, cp, di,
                     input logic [5:0] ov, input logic [1:0] st);
    logic [X_W-1:0] h, o;
    logic [PIX_W-1:0] m, e;
    @(posedge clk);
    dual_link_en <= dl;
    port_swap <= sw;
    dummy_mode <= dm;
    extras_suppress <= sp;
    compress_en <= cp;
    dither_en <= di;
    overlap_count <= ov;
    stall_req = st;
    repeat (5) send_line(1'b0);
    h = (dl || cp) ? 13'h0008 : 13'h0010;
    o = (sp || !dl) ? 13'h0000 : 13'(ov > 6'h20 ? 6'h20 : ov & 6'h3e);
    m = di ? 24'h00ff00 : 24'hffffff;
    chk_cnt({name, " left count"}, h + o, PANEL.cnt[sw]);
    chk_pix({name, " left first"}, pix(0, cp) & m,
            PANEL.first[sw] & m);
    e = o == 13'h0 ? pix(h - 1, cp) : (dm ? dummy_color : pix(h + o - 1, cp));
    chk_pix({name, " left last"}, e & m, PANEL.last[sw] & m);
    if (dl) begin
      e = o == 13'h0 ? pix(h, cp) : (dm ? dummy_color : pix(h - o, cp));
      chk_pix({name, " right first"}, e & m, PANEL.first[!sw] & m);
      chk_cnt({name, " right count"}, h + o, PANEL.cnt[!sw]);
    end
    if (dl && st == 2'h0)
      chk_cnt({name, " skew"}, 13'h0010,
              13'(PANEL.gap[!sw] - PANEL.gap[sw]));
    $display("test %s done", name);
  endtask

  // Main sequence.
  initial begin
    logic [1:0] ce;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // Two lines fill the buffers so no undefined pixel reaches a port.
    repeat (2) send_line(1'b0);
    run("split", 1, 0, 0, 0, 0, 0, 6'h00, 2'h1);
    run("swap", 1, 1, 0, 0, 0, 0, 6'h00, 2'h2);
    run("overlap", 1, 0, 0, 0, 0, 0, 6'h06, 2'h0);
    run("dummy", 1, 0, 1, 0, 0, 0, 6'h04, 2'h0);
    run("suppress", 1, 0, 1, 1, 0, 0, 6'h08, 2'h0);
    run("dither", 1, 0, 0, 0, 0, 1, 6'h00, 2'h0);
    send_line(1'b1);
    repeat (5) send_line(1'b0);
    chk_cnt("left vss lag", 13'h0004, 13'(PANEL.since[0]));
    chk_cnt("right vss lag", 13'h0002, 13'(PANEL.since[1]));
    $display("test vsync done");
    run("single", 0, 0, 0, 0, 0, 0, 6'h04, 2'h0);
    run("compress", 0, 0, 0, 0, 1, 0, 6'h00, 2'h0);
    // The second pass swaps the ports, so every route is seen both ways.
    for (int r = 0; r < 8; r++) begin
      @(posedge clk);
      port_swap <= r[2];
      cmd_valid <= 1'b1;
      cmd_route <= dls_cmd_route_type'(r[1:0]);
      cmd_data <= 8'h40 + 8'(r);
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      ce = r[2] ? {cmd_exp[r[1:0]][0], cmd_exp[r[1:0]][1]} : cmd_exp[r[1:0]];
      chk_cnt("cmd ports", 13'(ce),
              {11'h0, port_cmd_valid[1], port_cmd_valid[0]});
      if (ce[0])
        chk_cnt("cmd data", 13'h40 + 13'(r), 13'(port_cmd_data[0]));
    end
    $display("test commands done");
    @(posedge clk);
    color_bar_en <= 1'b1;
    port_swap <= 1'b0;
    // Bars start on raster line 16 and, with compression still on, reach
    // the left link three lines later: the 18th sync word after VSS.
    for (int w = 0; w < 90000; w++) begin
      if (PANEL.since[0] == 8'h12 && PANEL.cnt[0] > 13'h1) break;
      @(posedge clk);
    end
    chk_pix("colour bar", 24'hffffff, PANEL.first[0]);
    $display("test colour bar done");
    conclude();
  end
endmodule // tb
